/* File: core/video_crc_signature.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Remainder readable as low and high bytes.
// - Two hsyncs during blanking latch the CRC.
// - Accumulate only while blanking is inactive.
// - Write-only line select picks one of 24.
// - Codes map red, green, blue bits 0-7.
module video_crc_signature
	import video_crc_pkg::*;
#(
	parameter int crc_bits = crc_width,
	parameter int line_total = line_count
)
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] i_red,
	input wire logic [7:0] i_green,
	input wire logic [7:0] i_blue,
	input wire logic i_hsync,
	input wire logic i_blank
);

	// =====================================================================
	// Elaboration checks.
	if (crc_bits != high_byte_lsb + byte_width) begin : g_bad_crc_bits
		$error("crc_bits must fill exactly the low and high remainder bytes");
	end
	if (line_total != color_count * lines_per_color) begin : g_bad_line_total
		$error("line_total must equal the lines of the three colour buses");
	end
	if (line_total > (1 << code_width)) begin : g_bad_code_width
		$error("the line code is too narrow to reach every line");
	end

	// =====================================================================
	// Register bus decode.
	logic access;
	logic setup_read;
	logic write_select;
	assign access = psel & penable;
	assign setup_read = psel & ~penable & ~pwrite;
	assign write_select = access & pwrite & (paddr == addr_line_select);
	// The bus never stalls and never reports an error.
	assign pready = 1'h1;
	assign pslverr = 1'h0;

	// =====================================================================
	// Line-select register, written on the access edge only.
	// Only the code field is kept; the reserved bits have no effect.
	logic [code_width-1:0] crc_line_code;
	logic [code_width-1:0] next_crc_line_code;
	always_comb begin
		next_crc_line_code = crc_line_code;
		if (write_select) begin
			next_crc_line_code = pwdata[code_width-1:0];
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			crc_line_code <= line_code_reset;
		end else begin
			crc_line_code <= next_crc_line_code;
		end
	end

	// =====================================================================
	// Read data, captured in the setup cycle and held until the next read.
	// Capturing early keeps the byte steady if a retrace lands in the access phase.
	// The two bytes are not read atomically: a retrace between them mixes frames.
	logic [crc_bits-1:0] remainder_bits;
	logic [byte_width-1:0] remainder_low;
	logic [byte_width-1:0] remainder_high;
	logic [31:0] next_prdata;
	assign remainder_low = remainder_bits[low_byte_lsb +: byte_width];
	assign remainder_high = remainder_bits[high_byte_lsb +: byte_width];
	always_comb begin
		next_prdata = prdata;
		if (setup_read) begin
			next_prdata = read_zero;
			if (paddr == addr_remainder_low) begin
				next_prdata[byte_width-1:0] = remainder_low;
			end else if (paddr == addr_remainder_high) begin
				next_prdata[byte_width-1:0] = remainder_high;
			end else begin
				next_prdata = read_zero;
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prdata <= read_zero;
		end else begin
			prdata <= next_prdata;
		end
	end

	// =====================================================================
	// Line selection.
	logic sel_bit;
	crc_line_mux u_mux (
		.i_red(i_red),
		.i_green(i_green),
		.i_blue(i_blue),
		.i_code(crc_line_code),
		.o_bit(sel_bit)
	);

	// =====================================================================
	// Horizontal sync edge detector.
	// It resets to the idle level of the sync input, so reset makes no false edge.
	logic hsync_d;
	logic next_hsync_d;
	logic hsync_rise;
	always_comb begin
		next_hsync_d = i_hsync;
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hsync_d <= hsync_idle;
		end else begin
			hsync_d <= next_hsync_d;
		end
	end
	assign hsync_rise = i_hsync & ~hsync_d;

	// =====================================================================
	// Retrace detector: a second sync rise inside one blanking run.
	// Leaving blanking drops a half-seen pair, so line blanking never latches.
	retrace_state_t state;
	retrace_state_t next_state;
	logic latch_frame;
	always_comb begin
		next_state = state;
		latch_frame = 1'h0;
		case (state)
			st_active: begin
				if (i_blank && hsync_rise) begin
					next_state = st_blank_one;
				end
			end
			st_blank_one: begin
				if (!i_blank) begin
					next_state = st_active;
				end else if (hsync_rise) begin
					next_state = st_retrace;
					latch_frame = 1'h1;
				end
			end
			st_retrace: begin
				if (!i_blank) begin
					next_state = st_active;
				end
			end
			default: begin
				next_state = st_active;
			end
		endcase
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= st_active;
		end else begin
			state <= next_state;
		end
	end

	// =====================================================================
	// CRC accumulator, one selected bit per active pixel, most significant first.
	// Each bit above bit 0 takes its lower neighbour; each bit adds the feedback where the polynomial taps.
	logic [crc_bits-1:0] crc;
	logic [crc_bits-1:0] next_crc;
	logic [crc_bits-1:0] crc_shifted;
	logic feedback;
	assign feedback = crc[crc_bits-1] ^ sel_bit;
	for (genvar b = 0; b < crc_bits; b++) begin : g_crc_bit
		if (b == 0) begin : g_first
			assign crc_shifted[b] = feedback & crc_poly[b];
		end else begin : g_next
			assign crc_shifted[b] = crc[b-1] ^ (feedback & crc_poly[b]);
		end
	end
	always_comb begin
		next_crc = crc;
		if (latch_frame) begin
			next_crc = crc_seed;
		end else if (!i_blank) begin
			next_crc = crc_shifted;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			crc <= crc_seed;
		end else begin
			crc <= next_crc;
		end
	end

	// =====================================================================
	// Remainder, taken from the accumulator at retrace.
	logic [crc_bits-1:0] next_remainder_bits;
	always_comb begin
		next_remainder_bits = remainder_bits;
		if (latch_frame) begin
			next_remainder_bits = crc;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			remainder_bits <= crc_seed;
		end else begin
			remainder_bits <= next_remainder_bits;
		end
	end
endmodule : video_crc_signature

/* File: common/video_crc_pkg.sv */
package video_crc_pkg;
	// =====================================================================
	// Register indices; each register's byte address is its index times four.
	localparam logic [7:0] idx_remainder_low = 8'h3c;
	localparam logic [7:0] idx_remainder_high = 8'h3d;
	localparam logic [7:0] idx_line_select = 8'h3e;
	localparam int addr_width = 10;
	localparam logic [addr_width-1:0] addr_remainder_low = {idx_remainder_low, 2'h0};
	localparam logic [addr_width-1:0] addr_remainder_high = {idx_remainder_high, 2'h0};
	localparam logic [addr_width-1:0] addr_line_select = {idx_line_select, 2'h0};
	// =====================================================================
	// Field layout and constants.
	localparam int crc_width = 16;
	localparam int code_width = 5;
	localparam int lines_per_color = 8;
	localparam int line_count = 24;
	localparam logic [crc_width-1:0] crc_poly = 16'h1021;
	localparam logic [crc_width-1:0] crc_seed = 16'h0000;
	localparam logic [4:0] last_line_code = 5'h17;
	localparam logic [31:0] read_zero = 32'h0000_0000;
	localparam int byte_width = 8;
	localparam int low_byte_lsb = 0;
	localparam int high_byte_lsb = 8;
	localparam int color_count = 3;
	localparam logic [4:0] line_code_reset = 5'h00;
	localparam logic hsync_idle = 1'h0;
	// =====================================================================
	// Retrace detector states.
	typedef enum logic [1:0] {
		st_active = 2'b00,
		st_blank_one = 2'b01,
		st_retrace = 2'b10
	} retrace_state_t;
endpackage : video_crc_pkg

/* File: core/crc_line_mux.sv */
`timescale 1ns/10ps
module crc_line_mux
	import video_crc_pkg::*;
(
	input wire logic [7:0] i_red,
	input wire logic [7:0] i_green,
	input wire logic [7:0] i_blue,
	input wire logic [code_width-1:0] i_code,
	output logic o_bit
);
	logic [line_count-1:0] lines;
	assign lines = {i_blue, i_green, i_red};
	// Codes above the last line select zero so the CRC stays defined.
	always_comb begin
		if (i_code <= last_line_code) begin
			o_bit = lines[i_code];
		end else begin
			o_bit = 1'b0;
		end
	end
endmodule : crc_line_mux

/* File: verification/video_crc_sva.sv */
`timescale 1ns/10ps
module video_crc_sva
	import video_crc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	AST_RDY: assert property (pready) else $error("not ready");
	AST_ERR: assert property (!pslverr) else $error("error");
	AST_BYTE: assert property (psel && penable |-> !prdata[31:8]) else $error("wide");
	AST_WO: assert property (psel && penable && !pwrite && paddr == addr_line_select
		|-> prdata == read_zero) else $error("readable");
	AST_IDLE: assert property (!psel |=> $stable(prdata)) else $error("moved");
	AST_END: assert property (psel && penable |=> $stable(prdata)) else $error("held");
	cover property (psel && pwrite);
	cover property (penable && paddr == addr_remainder_low);
	cover property (penable && paddr == addr_remainder_high);
endmodule : video_crc_sva
bind video_crc_signature video_crc_sva u_sva (
	.i_clk(i_clk),
	.i_rst_b(i_rst_b),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr)
);

/* File: verification/video_source.sv */
`timescale 1ns/10ps
module video_source (
	input wire logic i_clk,
	output logic [23:0] o_pix,
	output logic o_hs,
	output logic o_bl
);
	logic [15:0] n = 16'h0;
	logic [5:0] c;
	always @(posedge i_clk) n <= n + 16'h1;
	assign c = 6'(n % 16'd48);
	assign o_pix = {n[9:2], ~n[7:0], n[7:0] ^ 8'h5a};
	assign o_hs = c % 6'd12 == 6'd9 || c == 6'd41;
	assign o_bl = c % 6'd12 > 6'd7 || c > 6'd35;
endmodule : video_source

/* File: verification/video_crc_signature_tb.sv */
`timescale 1ns/10ps
module video_crc_signature_tb
	import video_crc_pkg::*;
;
	logic i_clk = 0, i_rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, i_hsync, i_blank;
	logic [7:0] i_red, i_green, i_blue;
	logic [4:0] code;
	logic [9:0] paddr = 10'h0;
	logic [15:0] crc = 16'h0, rem;
	logic [31:0] pwdata = 32'h0, prdata;
	int checks = 0, n_fail = 0, cyc = 0;
	video_source src (.i_clk, .o_pix({i_blue, i_green, i_red}), .o_hs(i_hsync), .o_bl(i_blank));
	video_crc_signature dut (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.i_red(i_red),
		.i_green(i_green),
		.i_blue(i_blue),
		.i_hsync(i_hsync),
		.i_blank(i_blank)
	);
	initial forever #2 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (src.c == 6'd41) {rem, crc} <= {crc, crc_seed};
		else if (!i_blank) crc <= {crc[14:0], 1'b0} ^
			(crc[15] ^ src.o_pix[code] ? crc_poly : 16'h0);
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 9000) tally_and_finish(1);
	end
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge i_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge i_clk) penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		if (!w) chk(prdata, d);
		{psel, penable} <= 2'h0;
	endtask : xfer
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic tally_and_finish(input int extra);
		n_fail += extra;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (int k = 0; k < 24; k++) begin
			code <= 5'(k);
			xfer(1, addr_line_select, 32'(k));
			repeat (3) @(posedge i_clk iff src.c == 6'd0);
			xfer(0, addr_remainder_low, {24'h0, rem[7:0]});
			xfer(0, addr_remainder_high, {24'h0, rem[15:8]});
			$display("line %0d done", k);
		end
		xfer(0, addr_line_select, read_zero);
		tally_and_finish(0);
	end
endmodule : video_crc_signature_tb
